// ---- rtl/sisc_core.v ----
// command handler for the initialize and transfer-status functions
//
// Function
// - code 00h loads per-device parameters named by the command registers.
// - device fetches one tape byte or eight disk bytes from the data pointer.
// - a zero cylinder count puts the drive out of service until reloaded.
// - head count from byte 2 for hard disk, byte 3 for flexible disk.
// - sectors per track is parameter byte 4, one unsigned byte.
// - sector size is bytes 5 and 6, byte 6 the upper half.
// - initializing a hard or flexible disk sends its heads to track 0.
// - hard disk unit 0 runs the memory test first unless the modifier inhibits it.
// - memory test wipes all records; only hard disk unit 0 is then kept.
// - flexible byte 7 bits 1 to 7 zero selects default step and load timing.
// - 5.25 inch default timing is 22 ms step and 36 ms load.
// - 8 inch default timing is 11 ms step and 60 ms load.
// - tape parameter bit 0 marks the unit usable.
// - code 01h copies a 12-byte status buffer to the data pointer.
// - modifier bit 6 picks the short-term or long-term buffer.
// - copying the long-term buffer also overwrites the short-term one.
// - completion raises one interrupt unless the modifier suppresses it.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "sisc_defines.vh"

module sisc_core #(
  parameter MTEST_CYCLES = 16'h0100
) (
  input wire clk,
  input wire srst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg mem_read,
  output reg mem_write,
  output reg [31:0] mem_address,
  output reg [7:0] mem_writedata,
  input wire [7:0] mem_readdata,
  input wire mem_waitrequest,
  output reg irq,
  output reg home_req,
  output reg home_flex,
  output reg [1:0] home_unit
);

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_MTEST = 3'd1;
  localparam ST_FETCH = 3'd2;
  localparam ST_COMMIT = 3'd3;
  localparam ST_STORE = 3'd4;
  localparam ST_DONE = 3'd5;

  reg [2:0] state_reg;
  reg [7:0] wake_reg;
  reg [1:0] cls_reg;
  reg [1:0] unit_reg;
  reg [7:0] func_reg;
  reg [15:0] mod_reg;
  reg [31:0] ptr_reg;
  reg [3:0] rec_sel_reg;
  reg [3:0] flex_size_reg;
  reg busy_reg;
  reg done_reg;
  reg err_reg;
  reg [3:0] cnt_reg;
  reg [15:0] mtest_reg;
  reg [63:0] asm_reg;
  reg [95:0] st_short_reg;
  reg [95:0] st_long_reg;
  reg [11:0] valid_reg;
  reg [63:0] rec_mem [0:11];
  integer i;

  wire [63:0] sel_rec = rec_mem[rec_sel_reg];
  wire [1:0] sel_cls = rec_sel_reg[3:2];
  wire sel_valid = valid_reg[rec_sel_reg];
  wire bus_start = avs_write && !avs_waitrequest && avs_address == `SISC_OFF_WAKEUP;
  wire [7:0] wake_code = avs_writedata[7:0];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // record per class and unit
  function [3:0] rec_idx;
    input [1:0] cls;
    input [1:0] unit;
    begin
      rec_idx = {cls, unit};
    end
  endfunction

  function [7:0] byte_of;
    input [63:0] rec;
    input [2:0] n;
    begin
      byte_of = rec[n*8 +: 8];
    end
  endfunction

  function [7:0] heads_of;
    input [63:0] rec;
    input [1:0] cls;
    begin
      if (cls == `SISC_CLASS_FLEX)
        heads_of = byte_of(rec, 3'd3);
      else
        heads_of = byte_of(rec, 3'd2);
    end
  endfunction

  function [3:0] param_len;
    input [1:0] cls;
    begin
      if (cls == `SISC_CLASS_TAPE)
        param_len = `SISC_TAPE_PARAM_BYTES;
      else
        param_len = `SISC_DISK_PARAM_BYTES;
    end
  endfunction

  // ----------------------------------------
  // record decode for read-back
  // ----------------------------------------
  wire [15:0] sel_cyl = {byte_of(sel_rec, 3'd1), byte_of(sel_rec, 3'd0)};
  wire [7:0] sel_spt = byte_of(sel_rec, 3'd4);
  wire [15:0] sector_byte_size = {byte_of(sel_rec, 3'd6), byte_of(sel_rec, 3'd5)};
  wire [7:0] spare_cylinder_count = (sel_cls == `SISC_CLASS_HARD) ? byte_of(sel_rec, 3'd7) : 8'h00;
  wire [7:0] drive_vars = (sel_cls == `SISC_CLASS_FLEX) ? byte_of(sel_rec, 3'd7) : 8'h00;
  wire sel_in_service = sel_valid && (sel_cls == `SISC_CLASS_TAPE || sel_cyl != 16'h0000);
  wire tape_unit_present = sel_valid && sel_cls == `SISC_CLASS_TAPE &&
    sel_rec[`SISC_TAPE_AVAIL_BIT];
  wire flex_default = (sel_cls == `SISC_CLASS_FLEX) && drive_vars[7:1] == 7'h00;
  wire flex_8in = flex_size_reg[rec_sel_reg[1:0]];
  reg [7:0] step_ms;
  reg [7:0] load_ms;

  always @*
  begin
    step_ms = 8'h00;
    load_ms = 8'h00;
    if (flex_default && flex_8in)
    begin
      step_ms = `SISC_STEP_MS_8IN;
      load_ms = `SISC_LOAD_MS_8IN;
    end
    else if (flex_default)
    begin
      step_ms = `SISC_STEP_MS_5IN;
      load_ms = `SISC_LOAD_MS_5IN;
    end
  end

  reg [31:0] rd_mux;

  always @*
  begin
    case (avs_address)
      `SISC_OFF_WAKEUP: rd_mux = {24'h000000, wake_reg};
      `SISC_OFF_CMD: rd_mux = {8'h00, func_reg, 6'h00, unit_reg, 6'h00, cls_reg};
      `SISC_OFF_MODIFIER: rd_mux = {16'h0000, mod_reg};
      `SISC_OFF_DATA_PTR: rd_mux = ptr_reg;
      `SISC_OFF_STATUS: rd_mux = {28'h0000000, irq, err_reg, done_reg, busy_reg};
      `SISC_OFF_REC_SEL: rd_mux = {28'h0000000, rec_sel_reg};
      `SISC_OFF_REC_GEOM: rd_mux = {sel_spt, heads_of(sel_rec, sel_cls), sel_cyl};
      `SISC_OFF_REC_FMT: rd_mux = {5'h00, tape_unit_present, sel_in_service, sel_valid,
        spare_cylinder_count, sector_byte_size};
      `SISC_OFF_REC_TIME: rd_mux = {drive_vars, 7'h00, !flex_default, load_ms, step_ms};
      `SISC_OFF_FLEX_SIZE: rd_mux = {28'h0000000, flex_size_reg};
      `SISC_OFF_ST_SHORT: rd_mux = st_short_reg[31:0];
      6'h2c: rd_mux = st_short_reg[63:32];
      6'h30: rd_mux = st_short_reg[95:64];
      `SISC_OFF_ST_LONG: rd_mux = st_long_reg[31:0];
      6'h38: rd_mux = st_long_reg[63:32];
      6'h3c: rd_mux = st_long_reg[95:64];
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // bus slave: one wait cycle per access
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
      wake_reg <= 8'h00;
      cls_reg <= 2'h0;
      unit_reg <= 2'h0;
      func_reg <= 8'h00;
      mod_reg <= 16'h0000;
      ptr_reg <= 32'h00000000;
      rec_sel_reg <= 4'h0;
      flex_size_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      cnt_reg <= 4'h0;
      mtest_reg <= 16'h0000;
      asm_reg <= 64'h0;
      st_short_reg <= 96'h0;
      st_long_reg <= 96'h0;
      valid_reg <= 12'h000;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      mem_address <= 32'h00000000;
      mem_writedata <= 8'h00;
      irq <= 1'b0;
      home_req <= 1'b0;
      home_flex <= 1'b0;
      home_unit <= 2'h0;
    end
    else
    begin
      home_req <= 1'b0;
      // command fields are frozen while a command runs
      if (avs_write && !avs_waitrequest && !busy_reg)
      begin
        case (avs_address)
          `SISC_OFF_CMD:
          begin
            cls_reg <= avs_writedata[1:0];
            unit_reg <= avs_writedata[9:8];
            func_reg <= avs_writedata[23:16];
          end
          `SISC_OFF_MODIFIER: mod_reg <= avs_writedata[15:0];
          `SISC_OFF_DATA_PTR: ptr_reg <= avs_writedata;
          `SISC_OFF_REC_SEL: rec_sel_reg <= avs_writedata[3:0];
          `SISC_OFF_FLEX_SIZE: flex_size_reg <= avs_writedata[3:0];
          `SISC_OFF_ST_SHORT: st_short_reg[31:0] <= avs_writedata;
          6'h2c: st_short_reg[63:32] <= avs_writedata;
          6'h30: st_short_reg[95:64] <= avs_writedata;
          `SISC_OFF_ST_LONG: st_long_reg[31:0] <= avs_writedata;
          6'h38: st_long_reg[63:32] <= avs_writedata;
          6'h3c: st_long_reg[95:64] <= avs_writedata;
          default: ;
        endcase
      end
      if (bus_start)
        wake_reg <= wake_code;
      if (bus_start && wake_code == `SISC_WAKE_RESET)
      begin
        // board reset forgets every record; host must initialize again
        state_reg <= ST_IDLE;
        busy_reg <= 1'b0;
        valid_reg <= 12'h000;
        mem_read <= 1'b0;
        mem_write <= 1'b0;
        irq <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (bus_start && wake_code == `SISC_WAKE_START)
            begin
              busy_reg <= 1'b1;
              done_reg <= 1'b0;
              err_reg <= 1'b0;
              irq <= 1'b0;
              cnt_reg <= 4'h0;
              mtest_reg <= 16'h0000;
              asm_reg <= 64'h0;
              mem_address <= ptr_reg;
              if (func_reg == `SISC_FUNC_INIT && cls_reg != 2'h3)
              begin
                if (cls_reg == `SISC_CLASS_HARD && unit_reg == 2'h0 &&
                    !mod_reg[`SISC_MOD_NO_MTEST])
                  state_reg <= ST_MTEST;
                else
                begin
                  state_reg <= ST_FETCH;
                  mem_read <= 1'b1;
                end
              end
              else if (func_reg == `SISC_FUNC_XFER_STATUS)
              begin
                if (mod_reg[`SISC_MOD_LONG_BUF])
                begin
                  st_short_reg <= st_long_reg;
                  mem_writedata <= st_long_reg[7:0];
                end
                else
                  mem_writedata <= st_short_reg[7:0];
                state_reg <= ST_STORE;
                mem_write <= 1'b1;
              end
              else
              begin
                err_reg <= 1'b1;
                state_reg <= ST_DONE;
              end
            end
          end
          ST_MTEST:
          begin
            valid_reg <= 12'h000;
            mtest_reg <= mtest_reg + 16'h0001;
            if (mtest_reg == MTEST_CYCLES - 16'h0001)
            begin
              state_reg <= ST_FETCH;
              mem_read <= 1'b1;
            end
          end
          ST_FETCH:
          begin
            if (!mem_waitrequest)
            begin
              asm_reg[cnt_reg[2:0]*8 +: 8] <= mem_readdata;
              cnt_reg <= cnt_reg + 4'h1;
              mem_address <= mem_address + 32'h00000001;
              if (cnt_reg == param_len(cls_reg) - 4'h1)
              begin
                mem_read <= 1'b0;
                state_reg <= ST_COMMIT;
              end
            end
          end
          ST_COMMIT:
          begin
            valid_reg[rec_idx(cls_reg, unit_reg)] <= 1'b1;
            if (cls_reg != `SISC_CLASS_TAPE)
            begin
              home_req <= 1'b1;
              home_flex <= cls_reg == `SISC_CLASS_FLEX;
              home_unit <= unit_reg;
            end
            state_reg <= ST_DONE;
          end
          ST_STORE:
          begin
            if (!mem_waitrequest)
            begin
              cnt_reg <= cnt_reg + 4'h1;
              mem_address <= mem_address + 32'h00000001;
              mem_writedata <= st_short_reg[(cnt_reg == 4'hb ? 4'h0 : cnt_reg + 4'h1)*8 +: 8];
              if (cnt_reg == `SISC_STATUS_BYTES - 4'h1)
              begin
                mem_write <= 1'b0;
                state_reg <= ST_DONE;
              end
            end
          end
          ST_DONE:
          begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            irq <= !mod_reg[`SISC_MOD_NO_IRQ];
            state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // record store; a single write port keeps this an inferable memory
  always @(posedge clk)
  begin
    if (state_reg == ST_COMMIT)
      rec_mem[rec_idx(cls_reg, unit_reg)] <= asm_reg;
  end

  initial
  begin
    for (i = 0; i < 12; i = i + 1)
      rec_mem[i] = 64'h0;
  end

endmodule

// ---- rtl/sisc_defines.vh ----
// constants for the storage init and status command handler
`ifndef SISC_DEFINES_VH
`define SISC_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SISC_OFF_WAKEUP 6'h00
`define SISC_OFF_CMD 6'h04
`define SISC_OFF_MODIFIER 6'h08
`define SISC_OFF_DATA_PTR 6'h0c
`define SISC_OFF_STATUS 6'h10
`define SISC_OFF_REC_SEL 6'h14
`define SISC_OFF_REC_GEOM 6'h18
`define SISC_OFF_REC_FMT 6'h1c
`define SISC_OFF_REC_TIME 6'h20
`define SISC_OFF_FLEX_SIZE 6'h24
`define SISC_OFF_ST_SHORT 6'h28
`define SISC_OFF_ST_LONG 6'h34

// ----------------------------------------
// wake-up codes and function codes
// ----------------------------------------
`define SISC_WAKE_CLEAR 8'h00
`define SISC_WAKE_START 8'h01
`define SISC_WAKE_RESET 8'h02
`define SISC_FUNC_INIT 8'h00
`define SISC_FUNC_XFER_STATUS 8'h01

// ----------------------------------------
// device classes and field positions
// ----------------------------------------
`define SISC_CLASS_HARD 2'h0
`define SISC_CLASS_FLEX 2'h1
`define SISC_CLASS_TAPE 2'h2
`define SISC_MOD_NO_IRQ 0
`define SISC_MOD_NO_MTEST 1
`define SISC_MOD_LONG_BUF 6
`define SISC_TAPE_AVAIL_BIT 0
`define SISC_DISK_PARAM_BYTES 4'h8
`define SISC_TAPE_PARAM_BYTES 4'h1
`define SISC_STATUS_BYTES 4'hc

// ----------------------------------------
// flexible drive default timings, in ms
// ----------------------------------------
`define SISC_STEP_MS_5IN 8'h16
`define SISC_LOAD_MS_5IN 8'h24
`define SISC_STEP_MS_8IN 8'h0b
`define SISC_LOAD_MS_8IN 8'h3c

`endif

// ---- sim/sisc_core_checker.sv ----
// port assertions for the command handler
`timescale 1ns/10ps
module sisc_core_checker (
  input wire clk,
  input wire srst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire mem_read,
  input wire mem_write,
  input wire [31:0] mem_address,
  input wire [7:0] mem_writedata,
  input wire [7:0] mem_readdata,
  input wire mem_waitrequest,
  input wire irq,
  input wire home_req,
  input wire home_flex,
  input wire [1:0] home_unit
);
  reg [3:0] rd_cnt_reg;
  reg [3:0] wr_cnt_reg;
  wire wake = avs_write && !avs_waitrequest && avs_address == 6'h00;
  // ----------------------------------------
  // byte counts of one command
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (srst || wake)
    begin
      rd_cnt_reg <= 4'h0;
      wr_cnt_reg <= 4'h0;
    end
    else
    begin
      rd_cnt_reg <= rd_cnt_reg + {3'h0, mem_read && !mem_waitrequest};
      wr_cnt_reg <= wr_cnt_reg + {3'h0, mem_write && !mem_waitrequest};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_AVS_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("register access not answered after one wait");
  AST_AVS_LOW_ONCE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_IRQ_STANDS: assert property (irq && !wake |=> irq)
    else $error("interrupt dropped without a wake-up write");
  AST_IRQ_AT_END: assert property ($rose(irq) |-> !mem_read && !mem_write)
    else $error("interrupt raised during memory traffic");
  AST_MEM_EXCL: assert property (!(mem_read && mem_write))
    else $error("memory read and write together");
  AST_MEM_HOLD: assert property (mem_read && mem_waitrequest |=>
    mem_read && $stable(mem_address)) else $error("memory read dropped before answer");
  AST_RD_NEXT: assert property (mem_read && !mem_waitrequest ##1 mem_read |->
    mem_address == $past(mem_address) + 32'h1) else $error("fetch address not consecutive");
  AST_WR_NEXT: assert property (mem_write && !mem_waitrequest ##1 mem_write |->
    mem_address == $past(mem_address) + 32'h1) else $error("status address not consecutive");
  AST_RD_MAX: assert property (rd_cnt_reg <= 4'h8)
    else $error("more than eight parameter bytes fetched");
  AST_WR_MAX: assert property (wr_cnt_reg <= 4'hc)
    else $error("more than twelve status bytes written");
  AST_HOME_PULSE: assert property (home_req |=> !home_req)
    else $error("home request longer than one cycle");
endmodule

// ---- sim/sisc_mem_model.sv ----
// host memory answering the handler's byte requests
`timescale 1ns/10ps
module sisc_mem_model (
  input wire clk,
  input wire stall,
  input wire mem_read,
  input wire mem_write,
  input wire [31:0] mem_address,
  input wire [7:0] mem_writedata,
  output wire [7:0] mem_readdata,
  output reg mem_waitrequest
);
  reg [7:0] mem [0:255];
  reg [7:0] last_reg;
  wire take = (mem_read || mem_write) && !mem_waitrequest;
  // released data lines show the inverse of the last byte, never a stale copy
  assign mem_readdata = (mem_read && !mem_waitrequest) ? mem[mem_address[7:0]] : ~last_reg;
  initial
  begin
    mem_waitrequest = 1'b1;
    last_reg = 8'h00;
  end
  always @(posedge clk)
  begin
    mem_waitrequest <= !((mem_read || mem_write) && mem_waitrequest && !stall);
    if (take && mem_read)
      last_reg <= mem[mem_address[7:0]];
    if (take && mem_write)
      mem[mem_address[7:0]] <= mem_writedata;
  end
endmodule

// ---- sim/sisc_core_bench.sv ----
// self-checking bench for the command handler
`timescale 1ns/10ps
module sisc_core_bench;
  reg clk, srst, avs_read, avs_write, stall;
  reg [5:0] avs_address;
  reg [31:0] avs_writedata, seed, rnd, rd;
  wire [31:0] avs_readdata, mem_address;
  wire avs_waitrequest, mem_read, mem_write, mem_waitrequest, irq, home_req, home_flex;
  wire [7:0] mem_writedata, mem_readdata;
  wire [1:0] home_unit;
  integer mismatches, samples_checked, cyc, home_cnt, i;
  reg [31:0] eg[0:15], ef[0:15], et[0:15], mg[0:15], mf[0:15], mt[0:15], st[0:5];
  reg [7:0] pb[0:7];
  reg [2:0] home_last;
  reg [3:0] fsz;
  always #4 clk = ~clk;
  sisc_core #(.MTEST_CYCLES(16'h0004)) i_sisc_core (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_read(mem_read), .mem_write(mem_write),
    .mem_address(mem_address), .mem_writedata(mem_writedata), .mem_readdata(mem_readdata),
    .mem_waitrequest(mem_waitrequest), .irq(irq), .home_req(home_req),
    .home_flex(home_flex), .home_unit(home_unit));
  sisc_mem_model i_sisc_mem_model (.clk(clk), .stall(stall), .mem_read(mem_read),
    .mem_write(mem_write), .mem_address(mem_address), .mem_writedata(mem_writedata),
    .mem_readdata(mem_readdata), .mem_waitrequest(mem_waitrequest));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task print_verdict;
    begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // ----------------------------------------
  // stall pattern, home monitor, hang guard
  // ----------------------------------------
  always @(posedge clk)
  begin
    seed = lfsr(seed);
    stall <= seed[3] & seed[7];
    cyc = cyc + 1;
    if (home_req === 1'b1)
    begin
      home_cnt = home_cnt + 1;
      home_last = {home_flex, home_unit};
    end
    if (cyc == 30000)
    begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  end
  task bus(input w, input [5:0] a, input [31:0] d);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
    end
  endtask
  task run(input [1:0] c, input [1:0] u, input [7:0] f, input [15:0] m, input [7:0] p);
    begin
      bus(1'b1, 6'h04, {8'h00, f, 6'h00, u, 6'h00, c});
      bus(1'b1, 6'h08, {16'h0000, m});
      bus(1'b1, 6'h0c, {24'h0, p});
      bus(1'b1, 6'h00, 32'h1);
      rd = 32'h1;
      while (rd[0] !== 1'b0)
        bus(1'b0, 6'h10, 32'h0);
      cmp({31'h0, irq}, {31'h0, !m[0]});
    end
  endtask
  task chk(input [3:0] x);
    begin
      bus(1'b1, 6'h14, {28'h0, x});
      bus(1'b0, 6'h18, 32'h0);
      cmp(rd & mg[x], eg[x] & mg[x]);
      bus(1'b0, 6'h1c, 32'h0);
      cmp(rd & mf[x], ef[x] & mf[x]);
      bus(1'b0, 6'h20, 32'h0);
      cmp(rd & mt[x], et[x] & mt[x]);
    end
  endtask
  task fill;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1)
      begin
        rnd = lfsr(rnd);
        pb[k] = rnd[7:0];
      end
    end
  endtask
  task init(input [1:0] c, input [1:0] u, input [15:0] m);
    integer k, h0;
    reg [3:0] x;
    reg fd;
    begin
      x = {c, u};
      fd = pb[7][7:1] == 7'h0;
      for (k = 0; k < 8; k = k + 1)
        i_sisc_mem_model.mem[8'h40 + k] = pb[k]; // host-chosen size and spares
      h0 = home_cnt;
      run(c, u, 8'h00, m, 8'h40);
      if (c == 2'h0 && u == 2'h0 && !m[1])
        for (k = 0; k < 16; k = k + 1)
        begin
          mf[k] = 32'h03000000;
          ef[k] = 32'h0;
          mg[k] = 32'h0;
          mt[k] = 32'h0;
        end
      eg[x] = {pb[4], (c == 2'h1) ? pb[3] : pb[2], pb[1], pb[0]};
      ef[x] = {5'h0, pb[0][0], (c == 2'h2) || {pb[1], pb[0]} != 16'h0, 1'b1,
        (c == 2'h0) ? pb[7] : 8'h00, pb[6], pb[5]};
      et[x] = {pb[7], 7'h0, !fd, fd ? (fsz[u] ? 16'h3c0b : 16'h2416) : 16'h0};
      mg[x] = (c == 2'h2) ? 32'h0 : 32'hffffffff;
      mf[x] = (c == 2'h2) ? 32'h07000000 : (c == 2'h1) ? 32'h0300ffff : 32'h03ffffff;
      mt[x] = (c == 2'h1) ? 32'hffffffff : 32'h0;
      cmp(home_cnt - h0, {31'h0, c != 2'h2});
      if (c != 2'h2)
        cmp({29'h0, home_last}, {29'h0, c == 2'h1, u});
      chk(x);
    end
  endtask
  task xchk(input integer b);
    integer k;
    begin
      for (k = 0; k < 12; k = k + 1)
        cmp({24'h0, i_sisc_mem_model.mem[8'h80 + k]}, {24'h0, st[b + k / 4][8 * (k % 4) +: 8]});
      for (k = 0; k < 3; k = k + 1)
      begin
        bus(1'b0, 6'h28 + 6'h4 * k[5:0], 32'h0);
        cmp(rd, st[b + k]);
      end
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    stall = 1'b0;
    seed = 32'h14438f0b;
    rnd = 32'h14438f0b;
    mismatches = 0;
    samples_checked = 0;
    cyc = 0;
    home_cnt = 0;
    home_last = 3'h0;
    fsz = 4'h5;
    for (i = 0; i < 16; i = i + 1)
    begin
      eg[i] = 32'h0;
      ef[i] = 32'h0;
      et[i] = 32'h0;
      mg[i] = 32'h0;
      mt[i] = 32'h0;
      mf[i] = 32'h03000000;
    end
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 6'h10, 32'h0);
    cmp(rd, 32'h0);
    chk(4'h0);
    // board reset, then the full load sequence
    bus(1'b1, 6'h00, 32'h2);
    bus(1'b1, 6'h00, 32'h0);
    bus(1'b1, 6'h24, {28'h0, fsz});
    fill;
    pb[0] = 8'h01;
    init(2'h2, 2'h1, 16'h0);
    fill;
    pb[3] = 8'h00;
    init(2'h0, 2'h0, 16'h0);
    chk(4'h9);
    // every flexible unit, last one with explicit timing
    for (i = 0; i < 4; i = i + 1)
    begin
      fill;
      pb[2] = 8'h00;
      pb[7] = (i == 3) ? (pb[7] | 8'h02) : (pb[7] & 8'h01);
      init(2'h1, i[1:0], 16'h0);
    end
    fill;
    pb[3] = 8'h00;
    init(2'h0, 2'h0, 16'h2);
    chk(4'h4);
    pb[0] = 8'h00;
    pb[1] = 8'h00;
    init(2'h0, 2'h1, 16'h0);
    pb[0] = 8'h01;
    init(2'h0, 2'h1, 16'h0);
    fill;
    pb[0] = 8'h00;
    init(2'h2, 2'h2, 16'h1);
    for (i = 0; i < 6; i = i + 1)
    begin
      rnd = lfsr(rnd);
      st[i] = rnd;
      bus(1'b1, 6'h28 + 6'h4 * i[5:0], rnd);
    end
    run(2'h0, 2'h0, 8'h01, 16'h0000, 8'h80);
    xchk(0);
    run(2'h0, 2'h0, 8'h01, 16'h0041, 8'h80);
    xchk(3);
    run(2'h0, 2'h0, 8'h05, 16'h0000, 8'h40);
    cmp({31'h0, rd[2]}, 32'h1);
    run(2'h3, 2'h0, 8'h00, 16'h0000, 8'h40);
    cmp({31'h0, rd[2]}, 32'h1);
    print_verdict;
  end
endmodule
bind sisc_core sisc_core_checker i_sisc_core_checker (.clk(clk), .srst(srst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .mem_read(mem_read), .mem_write(mem_write),
  .mem_address(mem_address), .mem_writedata(mem_writedata), .mem_readdata(mem_readdata),
  .mem_waitrequest(mem_waitrequest), .irq(irq), .home_req(home_req),
  .home_flex(home_flex), .home_unit(home_unit));
